// ### ssm_axil_slave.sv
// AXI4-Lite slave front end with simple register strobes.
`default_nettype none
module ssm_axil_slave (
  input wire logic core_clk_i, // System clock
  input wire logic sys_rst_i, // Asynchronous reset, active high
  input wire logic [ssm_pkg::ADDR_W-1:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i, // Write address valid
  output logic s_axi_awready_o, // Write address ready
  input wire logic [ssm_pkg::DATA_W-1:0] s_axi_wdata_i, // Write data
  input wire logic [ssm_pkg::STRB_W-1:0] s_axi_wstrb_i, // Byte strobes
  input wire logic s_axi_wvalid_i, // Write data valid
  output logic s_axi_wready_o, // Write data ready
  output logic [1:0] s_axi_bresp_o, // Write response
  output logic s_axi_bvalid_o, // Write response valid
  input wire logic s_axi_bready_i, // Write response ready
  input wire logic [ssm_pkg::ADDR_W-1:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i, // Read address valid
  output logic s_axi_arready_o, // Read address ready
  output logic [ssm_pkg::DATA_W-1:0] s_axi_rdata_o, // Read data
  output logic [1:0] s_axi_rresp_o, // Read response
  output logic s_axi_rvalid_o, // Read data valid
  input wire logic s_axi_rready_i, // Read data ready
  output logic wr_en_o, // One-cycle register write strobe
  output logic [ssm_pkg::ADDR_W-1:0] wr_addr_o, // Write register address
  output logic [ssm_pkg::DATA_W-1:0] wr_data_o, // Write data
  output logic [ssm_pkg::DATA_W-1:0] wr_mask_o, // Bit mask from strobes
  input wire logic wr_err_i, // Write address unmapped
  output logic [ssm_pkg::ADDR_W-1:0] rd_addr_o, // Read register address
  input wire logic [ssm_pkg::DATA_W-1:0] rd_data_i, // Read data from decode
  input wire logic rd_err_i // Read address unmapped
);
  import ssm_pkg::*;
  logic [STRB_W-1:0] wstrb; // Captured strobes
  logic aw_hs; // Address taken
  logic w_hs; // Data taken
  logic b_hs; // Response taken
  logic ar_hs; // Read address taken
  logic r_hs; // Read data taken

  // Handshake decode
  assign aw_hs = s_axi_awvalid_i & s_axi_awready_o;
  assign w_hs = s_axi_wvalid_i & s_axi_wready_o;
  assign b_hs = s_axi_bvalid_o & s_axi_bready_i;
  assign ar_hs = s_axi_arvalid_i & s_axi_arready_o;
  assign r_hs = s_axi_rvalid_o & s_axi_rready_i;
  // Both halves held and no response pending
  assign wr_en_o = ~s_axi_awready_o & ~s_axi_wready_o & ~s_axi_bvalid_o;
  assign rd_addr_o = s_axi_araddr_i;

  // Expand byte strobes into a bit mask
  for (genvar b = 0; b < STRB_W; b++) begin : g_mask
    assign wr_mask_o[8*b +: 8] = {8{wstrb[b]}};
  end

  // Write address channel
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_awready_o <= 1'b1;
      wr_addr_o <= '0;
    end else if (aw_hs) begin
      s_axi_awready_o <= 1'b0;
      wr_addr_o <= s_axi_awaddr_i;
    end else if (b_hs) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_wready_o <= 1'b1;
      wr_data_o <= '0;
      wstrb <= '0;
    end else if (w_hs) begin
      s_axi_wready_o <= 1'b0;
      wr_data_o <= s_axi_wdata_i;
      wstrb <= s_axi_wstrb_i;
    end else if (b_hs) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  // Write response follows the register strobe
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else if (wr_en_o) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
    end else if (b_hs) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Read channel answers one cycle after the address
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_data_i;
      s_axi_rresp_o <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
    end else if (r_hs) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule : ssm_axil_slave
`default_nettype wire

// ### ssm_far_side.sv
// Far-side model: threshold memory and converter, with a chosen answer delay.
`default_nettype none
module ssm_far_side (
  input wire logic core_clk_i, // System clock
  input wire logic rd_req_i, // Threshold read request
  output logic [15:0] rd_data_o, // Word at the pointer
  output logic rd_ack_o, // Read answer pulse
  input wire logic conv_start_i, // Conversion start pulse
  output logic conv_done_o, // Conversion done pulse
  output logic [11:0] conv_res_o, // Conversion result
  input wire logic [15:0] word_i, // Stored threshold word
  input wire logic [11:0] first_i, // First result of a run
  input wire logic [11:0] later_i, // Later results of a run
  input wire logic [3:0] dly_i // Answer delay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack = 1'b0; // Read answer
  logic done = 1'b0; // Conversion answer
  logic pend = 1'b0; // Conversion under way
  logic [3:0] w = 4'h0; // Wait count
  logic [1:0] n = 2'h0; // Conversions since the fetch
  // Answer once the wait count meets the delay
  always @(posedge core_clk_i) begin
    ack <= rd_req_i && !ack && w == dly_i;
    done <= pend && w == dly_i && !conv_start_i;
    w <= conv_start_i ? 4'h0 : w + 4'h1;
    pend <= conv_start_i || (pend && w != dly_i);
    n <= ack ? 2'h0 : n + {1'b0, done};
  end
  // Released lines show inverted data, so a late sample is caught
  assign rd_ack_o = ack;
  assign conv_done_o = done;
  assign rd_data_o = ack ? word_i : ~word_i;
  assign conv_res_o = !done ? ~later_i : (n == 2'h0 ? first_i : later_i);
endmodule : ssm_far_side
`default_nettype wire

// ### ssm_pkg.sv
// Shared constants for the supply monitor sequencer.
`default_nettype none
package ssm_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PTR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_THRESH = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h1C;
  // Control register fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_IREF_BIT = 1;
  localparam int CTRL_MEAS_LSB = 8;
  localparam int CTRL_REST_LSB = 16;
  localparam int CH_W = 5;
  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_STOP_BIT = 1;
  // Interrupt bits
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_STOP = 1;
  localparam int IRQ_MISS = 2;
  localparam int IRQ_N = 3;
  // Values after reset
  localparam logic RST_IREF = 1'b1;
  localparam logic [CH_W-1:0] RST_MEAS_CH = 5'h00;
  localparam logic [CH_W-1:0] RST_REST_CH = 5'h00;
  localparam logic [IRQ_N-1:0] RST_IRQ_EN = 3'h0;
  // Data widths of result and threshold
  localparam int RES_W = 12;
  localparam int THR_W = 16;
  // Loop counter values
  localparam logic [1:0] LOOP_IREF = 2'h2;
  localparam logic [1:0] LOOP_EXT = 2'h1;
  localparam logic [1:0] LOOP_STEP = 2'h1;
  localparam logic [1:0] LOOP_DONE = 2'h0;
  // Settling wait of the no-wait software trigger
  localparam int CLK_NS = 8;
  localparam int STAB_NS = 1000;
  localparam int STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 16;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ssm_pkg
`default_nettype wire

// ### ssm_top.sv
// Supply monitor sequencer: fetch threshold, measure, compare, wake or sleep.
// Summary of operation
// - Fetch two-byte threshold at pointer each run
// - Select internal reference as converter input
// - No-wait software start with automatic settling wait
// - Convert and copy result into result variable
// - Decrement loop; repeat conversion while nonzero
// - Loop reloads to two every internal reference run
// - External channel needs single conversion pass
// - Stop converter before channel change, compare
// - Reference deselected, external channel before STOP
// - Result at or above threshold wakes CPU
// - Otherwise return to STOP mode
// - Interval timer interrupt triggers each run
// - Twelve-bit unsigned results, sixteen-bit thresholds
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`default_nettype none
module ssm_top #(
  parameter int STAB_CYCLES = ssm_pkg::STAB_CYC
) (
  input wire logic core_clk_i, // System clock, 125 MHz
  input wire logic sys_rst_i, // Asynchronous reset, active high
  input wire logic [ssm_pkg::ADDR_W-1:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i, // Write address valid
  output logic s_axi_awready_o, // Write address ready
  input wire logic [ssm_pkg::DATA_W-1:0] s_axi_wdata_i, // Write data
  input wire logic [ssm_pkg::STRB_W-1:0] s_axi_wstrb_i, // Byte strobes
  input wire logic s_axi_wvalid_i, // Write data valid
  output logic s_axi_wready_o, // Write data ready
  output logic [1:0] s_axi_bresp_o, // Write response
  output logic s_axi_bvalid_o, // Write response valid
  input wire logic s_axi_bready_i, // Write response ready
  input wire logic [ssm_pkg::ADDR_W-1:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i, // Read address valid
  output logic s_axi_arready_o, // Read address ready
  output logic [ssm_pkg::DATA_W-1:0] s_axi_rdata_o, // Read data
  output logic [1:0] s_axi_rresp_o, // Read response
  output logic s_axi_rvalid_o, // Read data valid
  input wire logic s_axi_rready_i, // Read data ready
  input wire logic interval_timer_irq_i, // Interval detection pulse
  output logic mem_rd_req_o, // Threshold memory read request
  output logic [ssm_pkg::THR_W-1:0] mem_rd_addr_o, // Threshold pointer
  input wire logic [ssm_pkg::THR_W-1:0] mem_rd_data_i, // Two-byte word read
  input wire logic mem_rd_ack_i, // Read data valid
  output logic adc_enable_o, // Converter operating
  output logic internal_ref_select_o, // Converter input is reference
  output logic [ssm_pkg::CH_W-1:0] adc_channel_o, // External channel number
  output logic adc_start_o, // Conversion start pulse
  input wire logic adc_done_i, // Conversion finished pulse
  input wire logic [ssm_pkg::RES_W-1:0] conversion_result_word_i, // Result
  output logic cpu_wake_o, // Wake CPU pulse
  output logic stop_mode_o, // Device held in STOP
  output logic irq_o // Level interrupt
);
  import ssm_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_SELECT, ST_START, ST_SETTLE,
    ST_CONVERT, ST_UPDATE, ST_END, ST_RESTORE, ST_COMPARE
  } ssm_state_t;

  // Refuse a settling count the timer cannot hold
  if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << TMR_W)) begin : g_bad_stab
    $error("ssm_top: STAB_CYCLES out of range");
  end

  ssm_state_t state; // Sequencer state
  ssm_state_t next_state; // Next sequencer state
  logic armed; // Start bit accepted, awaiting triggers
  logic ctrl_iref; // Measure internal reference
  logic [CH_W-1:0] meas_ch; // Channel when not reference
  logic [CH_W-1:0] rest_ch; // Channel restored before STOP
  logic [THR_W-1:0] ptr; // Threshold pointer
  logic [THR_W-1:0] threshold_variable; // Fetched threshold
  logic [RES_W-1:0] result; // Conversion result variable
  logic [1:0] loop_cnt; // Remaining conversions
  logic [IRQ_N-1:0] irq_stat; // Sticky events
  logic [IRQ_N-1:0] irq_en; // Interrupt enables
  logic next_adc_start; // Conversion start next cycle
  logic tmr_done; // Settling finished
  logic wr_en; // Register write strobe
  logic [ADDR_W-1:0] wr_addr; // Register write address
  logic [DATA_W-1:0] wr_data; // Register write data
  logic [DATA_W-1:0] wr_mask; // Register write mask
  logic [ADDR_W-1:0] rd_addr; // Register read address
  logic wr_err; // Write address unmapped
  logic rd_err; // Read address unmapped
  logic [DATA_W-1:0] rd_data; // Read data from decode

  // Register bus front end
  ssm_axil_slave u_bus (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i),
    .s_axi_wstrb_i(s_axi_wstrb_i),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_mask_o(wr_mask),
    .wr_err_i(wr_err),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(rd_err)
  );

  // Register decode
  wire [DATA_W-1:0] ctrl_rd = (DATA_W'(rest_ch) << CTRL_REST_LSB)
    | (DATA_W'(meas_ch) << CTRL_MEAS_LSB) | (DATA_W'(ctrl_iref) << CTRL_IREF_BIT)
    | (DATA_W'(armed) << CTRL_START_BIT);
  wire [DATA_W-1:0] stat_rd = (DATA_W'(state != ST_IDLE) << STAT_BUSY_BIT)
    | (DATA_W'(stop_mode_o) << STAT_STOP_BIT);
  wire [DATA_W-1:0] wbits = wr_data & wr_mask;
  wire [DATA_W-1:0] ctrl_new = (ctrl_rd & ~wr_mask) | wbits;
  wire [DATA_W-1:0] ptr_new = (DATA_W'(ptr) & ~wr_mask) | wbits;
  wire [DATA_W-1:0] en_new = (DATA_W'(irq_en) & ~wr_mask) | wbits;
  wire wr_ctrl = wr_en && (wr_addr == OFF_CTRL);
  wire wr_ptr = wr_en && (wr_addr == OFF_PTR);
  wire wr_clr = wr_en && (wr_addr == OFF_IRQ_CLR);
  wire wr_irq_en = wr_en && (wr_addr == OFF_IRQ_EN);
  wire [IRQ_N-1:0] irq_clr = wr_clr ? wbits[IRQ_N-1:0] : '0;
  wire arm_set = wr_ctrl && wbits[CTRL_START_BIT] && (state == ST_IDLE);
  wire wr_mapped = wr_addr[1:0] == 2'h0 && wr_addr <= OFF_IRQ_EN;
  assign wr_err = !wr_mapped;
  assign rd_err = !(rd_addr[1:0] == 2'h0 && rd_addr <= OFF_IRQ_EN);
  assign rd_data =
    (rd_addr == OFF_CTRL) ? ctrl_rd :
    (rd_addr == OFF_PTR) ? DATA_W'(ptr) :
    (rd_addr == OFF_RESULT) ? DATA_W'(result) :
    (rd_addr == OFF_THRESH) ? DATA_W'(threshold_variable) :
    (rd_addr == OFF_STATUS) ? stat_rd :
    (rd_addr == OFF_IRQ_STAT) ? DATA_W'(irq_stat) :
    (rd_addr == OFF_IRQ_EN) ? DATA_W'(irq_en) : '0;

  // Sequencer decode
  wire trig = interval_timer_irq_i && armed && (state == ST_IDLE);
  wire [1:0] loop_dec = loop_cnt - LOOP_STEP;
  wire [1:0] loop_init = ctrl_iref ? LOOP_IREF : LOOP_EXT;
  wire low_supply = THR_W'(result) >= threshold_variable;
  wire ev_wake = (state == ST_COMPARE) && low_supply;
  wire ev_stop = (state == ST_COMPARE) && !low_supply;
  wire ev_miss = interval_timer_irq_i && armed && (state != ST_IDLE);
  wire [IRQ_N-1:0] irq_ev = {ev_miss, ev_stop, ev_wake};

  // Settling wait after a no-wait software start
  ssm_wait_timer #(.CNT_W(TMR_W)) u_settle (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(state == ST_START),
    .count_i(TMR_W'(STAB_CYCLES)),
    .done_o(tmr_done)
  );

  // Next state of the sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (trig) next_state = ST_FETCH;
      ST_FETCH: if (mem_rd_ack_i) next_state = ST_SELECT;
      ST_SELECT: next_state = ST_START;
      ST_START: next_state = ST_SETTLE;
      ST_SETTLE: if (tmr_done) next_state = ST_CONVERT;
      ST_CONVERT: if (adc_done_i) next_state = ST_UPDATE;
      ST_UPDATE: next_state = (loop_dec != LOOP_DONE) ? ST_CONVERT : ST_END;
      ST_END: next_state = ST_RESTORE;
      ST_RESTORE: next_state = ST_COMPARE;
      ST_COMPARE: next_state = ST_IDLE;
    endcase
  end
  assign next_adc_start = (next_state == ST_CONVERT) && (state != ST_CONVERT);

  // State register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) state <= ST_IDLE;
    else state <= next_state;
  end

  // Software control fields
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_iref <= RST_IREF;
      meas_ch <= RST_MEAS_CH;
      rest_ch <= RST_REST_CH;
      ptr <= '0;
      irq_en <= RST_IRQ_EN;
    end else begin
      if (wr_ctrl) begin
        ctrl_iref <= ctrl_new[CTRL_IREF_BIT];
        meas_ch <= ctrl_new[CTRL_MEAS_LSB +: CH_W];
        rest_ch <= ctrl_new[CTRL_REST_LSB +: CH_W];
      end
      if (wr_ptr) ptr <= ptr_new[THR_W-1:0];
      if (wr_irq_en) irq_en <= en_new[IRQ_N-1:0];
    end
  end

  // Arming by the start bit, disarm on wake; STOP flag
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      armed <= 1'b0;
      stop_mode_o <= 1'b0;
      cpu_wake_o <= 1'b0;
    end else begin
      cpu_wake_o <= ev_wake;
      if (arm_set) begin
        armed <= 1'b1;
        stop_mode_o <= 1'b1;
      end else if (trig) begin
        stop_mode_o <= 1'b0;
      end else if (ev_wake) begin
        armed <= 1'b0;
      end else if (ev_stop) begin
        stop_mode_o <= 1'b1;
      end
    end
  end

  // Threshold fetch, loop counter and result capture
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_rd_req_o <= 1'b0;
      mem_rd_addr_o <= '0;
      threshold_variable <= '0;
      result <= '0;
      loop_cnt <= LOOP_DONE;
    end else begin
      mem_rd_req_o <= (next_state == ST_FETCH);
      if (trig) mem_rd_addr_o <= ptr;
      if (trig) loop_cnt <= loop_init;
      else if (state == ST_UPDATE) loop_cnt <= loop_dec;
      if (state == ST_FETCH && mem_rd_ack_i) threshold_variable <= mem_rd_data_i;
      if (state == ST_CONVERT && adc_done_i) result <= conversion_result_word_i;
    end
  end

  // Converter control
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      adc_enable_o <= 1'b0;
      internal_ref_select_o <= 1'b0;
      adc_channel_o <= RST_REST_CH;
      adc_start_o <= 1'b0;
    end else begin
      adc_start_o <= next_adc_start;
      if (state == ST_START) adc_enable_o <= 1'b1;
      else if (state == ST_END) adc_enable_o <= 1'b0;
      if (state == ST_SELECT) begin
        internal_ref_select_o <= ctrl_iref;
        adc_channel_o <= meas_ch;
      end else if (state == ST_RESTORE) begin
        internal_ref_select_o <= 1'b0;
        adc_channel_o <= rest_ch;
      end
    end
  end

  // Sticky events, set wins over clear, and the interrupt level
  for (genvar i = 0; i < IRQ_N; i++) begin : g_irq
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) irq_stat[i] <= 1'b0;
      else irq_stat[i] <= irq_ev[i] | (irq_stat[i] & ~irq_clr[i]);
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) irq_o <= 1'b0;
    else irq_o <= |(irq_en & (irq_ev | (irq_stat & ~irq_clr)));
  end

  // Helper counter for settling length
  logic [TMR_W-1:0] settle_cnt;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) settle_cnt <= '0;
    else if (state == ST_SETTLE) settle_cnt <= settle_cnt + TMR_W'(1);
    else settle_cnt <= '0;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_trig;
    state == ST_IDLE && trig;
  endsequence
  sequence s_fetch_done;
    state == ST_FETCH && mem_rd_ack_i;
  endsequence

  run_trigger_a: assert property (s_trig |=> mem_rd_req_o && state == ST_FETCH)
    else $error("trigger did not start a threshold fetch");
  thresh_load_a: assert property (s_fetch_done |=>
    threshold_variable == $past(mem_rd_data_i) ##1 internal_ref_select_o == ctrl_iref)
    else $error("threshold or channel select wrong after fetch");
  iref_select_a: assert property (state == ST_SELECT && ctrl_iref |=> internal_ref_select_o)
    else $error("internal reference not selected");
  settle_len_a: assert property (state == ST_SETTLE && tmr_done |->
    settle_cnt == TMR_W'(STAB_CYCLES - 1) ##1 adc_start_o)
    else $error("settling wait length wrong");
  result_load_a: assert property (state == ST_CONVERT && adc_done_i |=>
    result == $past(conversion_result_word_i))
    else $error("result not captured");
  loop_back_a: assert property (state == ST_UPDATE && loop_cnt == LOOP_IREF |=>
    state == ST_CONVERT && adc_start_o && loop_cnt == LOOP_EXT)
    else $error("loop did not repeat conversion");
  loop_reload_a: assert property (s_trig |=> loop_cnt == ($past(ctrl_iref) ? 2'h2 : 2'h1))
    else $error("loop counter not reloaded");
  adc_off_a: assert property (state == ST_RESTORE || state == ST_COMPARE |-> !adc_enable_o)
    else $error("converter still running at channel change");
  iref_off_stop_a: assert property ($rose(stop_mode_o) |-> !internal_ref_select_o)
    else $error("reference selected while entering STOP");
  wake_low_a: assert property (state == ST_COMPARE && low_supply |=>
    cpu_wake_o && !stop_mode_o && !armed ##1 !cpu_wake_o)
    else $error("low supply did not wake CPU");
  stop_high_a: assert property (state == ST_COMPARE && !low_supply |=>
    stop_mode_o && !cpu_wake_o && armed)
    else $error("adequate supply did not return to STOP");
endmodule : ssm_top
`default_nettype wire

// ### ssm_top_test.sv
// Self-checking bench for the supply monitor sequencer.
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module ssm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ssm_pkg::*;
  logic core_clk_i = 1'b0; // Clock
  logic sys_rst_i = 1'b1; // Reset
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00; // Addresses
  logic [31:0] s_axi_wdata_i = 32'h0000_0000; // Write data
  logic [3:0] s_axi_wstrb_i = 4'hF; // All bytes
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0; // Write side
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, interval_timer_irq_i = 1'b0; // Read, trigger
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o; // Readies
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r; // Responses
  logic [31:0] s_axi_rdata_o, d; // Read data
  logic mem_rd_req_o, mem_rd_ack_i, adc_enable_o, internal_ref_select_o, adc_start_o; // Link
  logic adc_done_i, cpu_wake_o, stop_mode_o, irq_o; // Link and status
  logic [15:0] mem_rd_addr_o, mem_rd_data_i, thr = 16'h0000; // Pointer and words
  logic [11:0] conversion_result_word_i, ra = 12'h000, rb = 12'h000; // Results
  logic [4:0] adc_channel_o; // Channel
  logic [3:0] dly = 4'h0; // Far-side delay
  logic use_ref = 1'b1; // Reference expected at each start
  int err_count = 0, compares = 0, starts = 0, wakes = 0;
  ssm_top #(.STAB_CYCLES(4)) dut (.core_clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .interval_timer_irq_i, .mem_rd_req_o, .mem_rd_addr_o, .mem_rd_data_i, .mem_rd_ack_i,
    .adc_enable_o, .internal_ref_select_o, .adc_channel_o, .adc_start_o, .adc_done_i,
    .conversion_result_word_i, .cpu_wake_o, .stop_mode_o, .irq_o);
  ssm_far_side far (.core_clk_i, .rd_req_i(mem_rd_req_o), .rd_data_o(mem_rd_data_i),
    .rd_ack_o(mem_rd_ack_i), .conv_start_i(adc_start_o), .conv_done_o(adc_done_i),
    .conv_res_o(conversion_result_word_i), .word_i(thr), .first_i(ra), .later_i(rb),
    .dly_i(dly));
  initial forever #4 core_clk_i = ~core_clk_i;
  // Count starts and wakes, check the input choice and the pointer
  always @(posedge core_clk_i) begin
    if (adc_start_o) begin
      starts++;
      `CHK(internal_ref_select_o, use_ref)
    end
    if (cpu_wake_o) wakes++;
    if (mem_rd_ack_i) `CHK(mem_rd_addr_o, 16'h1234)
  end
  task automatic finish_test(input bit to);
    if (to) err_count++;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge core_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) break;
    end
    s_axi_bready_i <= 1'b0;
    if (k == 99) finish_test(1'b1);
    `CHK(s_axi_bresp_o, RESP_OKAY)
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge core_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o) break;
    end
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    if (k == 99) finish_test(1'b1);
  endtask : rd
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask : ck
  // One trigger, then wait for the wake pulse or the return to STOP
  task automatic run(input logic [15:0] t, input logic [11:0] a, b, input logic [3:0] l,
                     input int w, s);
    int k;
    thr <= t;
    ra <= a;
    rb <= b;
    dly <= l;
    starts = 0;
    wakes = 0;
    @(posedge core_clk_i);
    interval_timer_irq_i <= 1'b1;
    @(posedge core_clk_i);
    interval_timer_irq_i <= 1'b0;
    for (k = 0; k < 600 && !(wakes > 0 || (stop_mode_o && starts > 0)); k++)
      @(posedge core_clk_i);
    if (k == 600) finish_test(1'b1);
    repeat (2) @(posedge core_clk_i);
    `CHK(wakes, w)
    `CHK(starts, s)
    `CHK(stop_mode_o, (w == 0))
    `CHK(internal_ref_select_o, 1'b0)
    `CHK(adc_enable_o, 1'b0)
  endtask : run
  initial begin
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    ck(OFF_CTRL, 32'h0000_0002);
    rd(8'h24);
    `CHK(r, RESP_SLVERR)
    wr(OFF_IRQ_EN, 32'h0000_0003);
    wr(OFF_PTR, 32'h0000_1234);
    wr(OFF_CTRL, 32'h0000_0003);
    run(16'h0100, 12'h0FF, 12'h100, 4'h0, 1, 2);
    ck(OFF_RESULT, 32'h0000_0100);
    ck(OFF_THRESH, 32'h0000_0100);
    `CHK(irq_o, 1'b1)
    wr(OFF_IRQ_CLR, 32'h0000_0001);
    repeat (2) @(posedge core_clk_i);
    `CHK(irq_o, 1'b0)
    wr(OFF_CTRL, 32'h0000_0003);
    run(16'h0101, 12'hFFF, 12'h100, 4'h9, 0, 2);
    use_ref = 1'b0;
    wr(OFF_CTRL, 32'h0007_0301);
    run(16'h0101, 12'h800, 12'h000, 4'h5, 1, 1);
    `CHK(adc_channel_o, 5'h07)
    ck(OFF_RESULT, 32'h0000_0800);
    finish_test(1'b0);
  end
endmodule : ssm_top_test
`default_nettype wire

// ### ssm_wait_timer.sv
// Down-counting wait timer used for converter settling.
`default_nettype none
module ssm_wait_timer #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk_i, // System clock
  input wire logic sys_rst_i, // Asynchronous reset, active high
  input wire logic load_i, // Load a new count
  input wire logic [CNT_W-1:0] count_i, // Cycles to wait
  output logic done_o // High in the last waited cycle
);
  logic [CNT_W-1:0] cnt; // Remaining cycles

  // Refuse widths the counter cannot serve
  if (CNT_W < 2) begin : g_bad_width
    $error("ssm_wait_timer: CNT_W too small");
  end

  // Last cycle of the wait
  assign done_o = (cnt == CNT_W'(1));

  // Count down to zero and hold
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
    end else if (load_i) begin
      cnt <= count_i;
    end else if (cnt != '0) begin
      cnt <= cnt - CNT_W'(1);
    end
  end
endmodule : ssm_wait_timer
`default_nettype wire
